// ---- pkg/smm_gate_pkg.sv ----
package smm_gate_pkg;
   // Minimum lead of mask release ahead of the acknowledge, in I/O clocks
   localparam int unsigned MASK_LEAD_CLKS = 1;
   // Reset values of the glue outputs and of the processor acknowledge
   localparam logic MASK_RST = 1'b0;
   localparam logic REQ_RST  = 1'b0;
   localparam logic ACK_RST  = 1'b0;
   // Interlock strategy selected in the glue logic
   typedef enum logic [1:0] {
      MODE_HOLD_REQ = 2'b00,  // Hold off the request until the mask is released
      MODE_TIMED    = 2'b01,  // Release the mask and wait the lead before the request
      MODE_NONE     = 2'b11   // Management memory below 1 MB, no interlock needed
   } interlock_e;
   // Processor management-mode sequence
   typedef enum logic [2:0] {
      CPU_IDLE    = 3'b000,
      CPU_SAVE    = 3'b001,
      CPU_HANDLER = 3'b011,
      CPU_RESTORE = 3'b010
   } cpu_state_e;
   localparam logic [3:0] SAVE_CYCLES    = 4'h4;
   localparam logic [3:0] RESTORE_CYCLES = 4'h4;
endpackage : smm_gate_pkg

// ---- pkg/smm_link_if.sv ----
`timescale 1ns/100ps
interface smm_link_if;
   logic maskIn;        // Gated address-bit-20 mask seen by the processor
   logic smmRequest;    // Management interrupt request
   logic smmActiveAck;  // Processor is in management mode
   logic saveCycle;     // Processor issues a state-save bus cycle
   logic restoreDone;   // Last restore bus cycle finished
   modport cpu  (input maskIn, input smmRequest, output smmActiveAck,
                 output saveCycle, output restoreDone);
   modport glue (output maskIn, output smmRequest, input smmActiveAck,
                 input saveCycle, input restoreDone);
endinterface : smm_link_if

// ---- hw/smm_cpu_end.sv ----
`timescale 1ns/100ps
module smm_cpu_end
   import smm_gate_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rst,
   smm_link_if.cpu   link,
   input  wire logic nmiPin,       // Non-maskable interrupt request, one-cycle pulse
   input  wire logic intrPin,      // Maskable interrupt request, level
   input  wire logic ifFlag,       // Software interrupt-enable flag
   input  wire logic exceptEvt,    // Exception vectoring to trap/fault, pulse
   input  wire logic handlerDone,  // Handler executed resume, pulse
   output logic      nmiTaken,     // NMI serviced, one-cycle pulse
   output logic      intrTaken,    // Maskable interrupt taken, high one cycle after each cycle IF and intrPin are both set in the handler
   output logic      maskSeen      // Mask level sampled during save cycles
);
   import smm_gate_pkg::*;

   cpu_state_e state_q, state_d;   // Management-mode sequence
   logic [3:0] cnt_q, cnt_d;       // Bus-cycle counter for save/restore
   logic       nmiBlk_q, nmiBlk_d; // NMI blocked
   logic       ackOut_q, ackOut_d; // Acknowledge register
   logic       nmiT_q, nmiT_d;
   logic       intT_q, intT_d;
   logic       seen_q, seen_d;

   // Next-state logic for the processor end
   always_comb begin
      state_d  = state_q;
      cnt_d    = cnt_q;
      nmiBlk_d = nmiBlk_q;
      ackOut_d = ackOut_q;
      nmiT_d   = 1'b0;
      intT_d   = 1'b0;
      seen_d   = seen_q;
      unique case (state_q)
         CPU_IDLE: begin
            if (link.smmRequest) begin
               state_d  = CPU_SAVE;
               ackOut_d = 1'b1;
               nmiBlk_d = 1'b1;
               cnt_d    = SAVE_CYCLES;
               seen_d   = 1'b0;
            end
         end
         CPU_SAVE: begin
            // Save starts in the same clock the ack rises
            if (link.maskIn) begin
               seen_d = 1'b1;                 // Hazard flag: mask active during save
            end
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
               state_d = CPU_HANDLER;
            end
         end
         CPU_HANDLER: begin
            // Interrupt taken only with IF set; it re-opens NMI
            if (ifFlag && intrPin) begin
               intT_d   = 1'b1;
               nmiBlk_d = 1'b0;
            end
            // Implementation-specific: exceptions also re-open NMI
            if (exceptEvt) begin
               nmiBlk_d = 1'b0;
            end
            if (handlerDone) begin
               state_d = CPU_RESTORE;
               cnt_d   = RESTORE_CYCLES;
            end
         end
         CPU_RESTORE: begin
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
               state_d  = CPU_IDLE;
               ackOut_d = 1'b0;
               nmiBlk_d = 1'b0;
            end
         end
         default: begin
            state_d = CPU_IDLE;               // Illegal code recovers
         end
      endcase
      // NMI serviced only when not blocked
      if (nmiPin && !nmiBlk_d && !nmiBlk_q) begin
         nmiT_d = 1'b1;
      end
   end

   // State registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q  <= CPU_IDLE;
         cnt_q    <= 4'h0;
         nmiBlk_q <= 1'b0;
         ackOut_q <= ACK_RST;
         nmiT_q   <= 1'b0;
         intT_q   <= 1'b0;
         seen_q   <= 1'b0;
      end else begin
         state_q  <= state_d;
         cnt_q    <= cnt_d;
         nmiBlk_q <= nmiBlk_d;
         ackOut_q <= ackOut_d;
         nmiT_q   <= nmiT_d;
         intT_q   <= intT_d;
         seen_q   <= seen_d;
      end
   end

   assign link.smmActiveAck = ackOut_q;
   assign link.saveCycle    = (state_q == CPU_SAVE);
   assign link.restoreDone  = (state_q == CPU_RESTORE) && (cnt_q == 4'h1);
   assign nmiTaken  = nmiT_q;
   assign intrTaken = intT_q;
   assign maskSeen  = seen_q;
endmodule : smm_cpu_end

// ---- hw/smm_glue_end.sv ----
`timescale 1ns/100ps
module smm_glue_end
   import smm_gate_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   smm_link_if.glue        link,
   input  wire logic       maskReq,   // Legacy mask request from system, async
   input  wire logic       mgmtReq,   // Management interrupt source, async level
   input  wire interlock_e mode,      // Interlock strategy, static
   output logic            mgmtPend   // Request waiting on the interlock
);
   import smm_gate_pkg::*;

   logic maskS1_q, maskS2_q, reqS1_q, reqS2_q;  // Two-flop synchronisers
   logic ackS1_q, ackS2_q;
   logic inSmm_q, inSmm_d;      // Management window, start to last restore
   logic savedMask_q, savedMask_d;  // Mask level before entry
   logic maskOut_q, maskOut_d;
   logic reqOut_q, reqOut_d;
   logic lead_q, lead_d;        // One clock of released mask observed

   // Synchronise pin inputs before use
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         {maskS1_q, maskS2_q, reqS1_q, reqS2_q, ackS1_q, ackS2_q} <= 6'h00;
      end else begin
         maskS1_q <= maskReq;
         maskS2_q <= maskS1_q;
         reqS1_q  <= mgmtReq;
         reqS2_q  <= reqS1_q;
         ackS1_q  <= link.smmActiveAck;
         ackS2_q  <= ackS1_q;
      end
   end

   // Gate the mask around the management window
   always_comb begin
      inSmm_d     = inSmm_q;
      savedMask_d = savedMask_q;
      reqOut_d    = 1'b0;
      lead_d      = 1'b0;
      maskOut_d   = maskS2_q;
      if (!inSmm_q && reqS2_q) begin
         // Except in MODE_NONE, release mask first, request only after the lead
         if (mode == MODE_NONE) begin
            reqOut_d = 1'b1;
            inSmm_d  = 1'b1;
         end else begin
            maskOut_d = 1'b0;
            lead_d    = !maskOut_q;
            if (lead_q) begin
               reqOut_d    = 1'b1;
               inSmm_d     = 1'b1;
               savedMask_d = maskS2_q;
            end
         end
      end
      if (inSmm_q) begin
         // Suppress the mask throughout the mode, except in MODE_NONE
         reqOut_d = reqS2_q && !ackS2_q && !link.saveCycle;
         if (mode != MODE_NONE) begin
            maskOut_d = 1'b0;
         end
         if (link.restoreDone) begin
            inSmm_d = 1'b0;                   // Mask follows request again
         end
      end
   end

   // Registered glue outputs, inactive in reset
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         inSmm_q     <= 1'b0;
         savedMask_q <= MASK_RST;
         maskOut_q   <= MASK_RST;
         reqOut_q    <= REQ_RST;
         lead_q      <= 1'b0;
      end else begin
         inSmm_q     <= inSmm_d;
         savedMask_q <= savedMask_d;
         maskOut_q   <= maskOut_d;
         reqOut_q    <= reqOut_d;
         lead_q      <= lead_d;
      end
   end

   assign link.maskIn     = maskOut_q;
   assign link.smmRequest = reqOut_q;
   assign mgmtPend        = reqS2_q && !inSmm_q;
endmodule : smm_glue_end

// ---- dv/smm_gate_properties.sv ----
`timescale 1ns/100ps
module smm_gate_properties (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic maskIn,
   input wire logic smmRequest,
   input wire logic smmActiveAck,
   input wire logic saveCycle,
   input wire logic restoreDone
);
   // All checks sample on the bus clock and rest while reset is high
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   lead_before_ack_a: assert property ($rose(smmActiveAck) |-> !$past(maskIn))
      else $error("mask not released a clock ahead of ack");
   req_after_mask_a: assert property ($rose(smmRequest) |-> !$past(maskIn))
      else $error("request raised while mask active");
   mask_blocked_a: assert property (smmActiveAck |-> !maskIn)
      else $error("mask active inside management mode");
   save_with_ack_a: assert property ($rose(smmActiveAck) |-> saveCycle)
      else $error("save did not start with ack");
   save_length_a: assert property ($rose(saveCycle) |-> saveCycle[*4] ##1 !saveCycle)
      else $error("save run not four cycles");
   ack_answer_a: assert property ($rose(smmRequest) |=> smmActiveAck)
      else $error("ack not one cycle after request");
   ack_release_a: assert property (restoreDone |=> !smmActiveAck)
      else $error("ack held past last restore");
   restore_pulse_a: assert property (restoreDone |-> smmActiveAck ##1 !restoreDone)
      else $error("restore done not a single pulse in mode");
endmodule : smm_gate_properties

// ---- dv/tb_smm_entry_addr_mask_gate.sv ----
`timescale 1ns/100ps
module tb_smm_entry_addr_mask_gate;
   import smm_gate_pkg::*;
   typedef struct packed {interlock_e mode; logic maskReq;} row_s;
   logic       ref_clk = 1'b0;
   logic       rst = 1'b1;
   logic       nmiPin = 1'b0, intrPin = 1'b0, ifFlag = 1'b0, exceptEvt = 1'b0;
   logic       handlerDone = 1'b0, maskReq = 1'b0, mgmtReq = 1'b0;
   interlock_e mode = MODE_TIMED;
   logic       nmiTaken, intrTaken, maskSeen, mgmtPend;
   int         bad_count = 0, tests_run = 0, nmiCount = 0, intrCount = 0, got;
   // Ordinary cases: strategy and mask level; mask must return to maskReq after exit
   row_s       rows [5] = '{'{MODE_TIMED, 1'b1}, '{MODE_HOLD_REQ, 1'b1},
                            '{MODE_TIMED, 1'b0}, '{MODE_HOLD_REQ, 1'b0}, '{MODE_NONE, 1'b0}};
   always #5 ref_clk = ~ref_clk;
   smm_link_if link ();
   smm_cpu_end i_smm_cpu_end (.ref_clk(ref_clk), .rst(rst), .link(link), .nmiPin(nmiPin),
      .intrPin(intrPin), .ifFlag(ifFlag), .exceptEvt(exceptEvt), .handlerDone(handlerDone),
      .nmiTaken(nmiTaken), .intrTaken(intrTaken), .maskSeen(maskSeen));
   smm_glue_end i_smm_glue_end (.ref_clk(ref_clk), .rst(rst), .link(link), .maskReq(maskReq),
      .mgmtReq(mgmtReq), .mode(mode), .mgmtPend(mgmtPend));
   smm_gate_properties i_smm_gate_properties (.ref_clk(ref_clk), .rst(rst),
      .maskIn(link.maskIn), .smmRequest(link.smmRequest), .smmActiveAck(link.smmActiveAck),
      .saveCycle(link.saveCycle), .restoreDone(link.restoreDone));
   // Counting pulses keeps a late pulse from slipping past a one-cycle look
   always @(posedge ref_clk) begin
      if (nmiTaken === 1'b1) nmiCount <= nmiCount + 1;
      if (intrTaken === 1'b1) intrCount <= intrCount + 1;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   // Drive the system request and wait, bounded, for the acknowledge
   task automatic enter(input interlock_e m, input logic mr);
      int n;
      mode <= m;
      maskReq <= mr;
      repeat (5) @(posedge ref_clk);
      mgmtReq <= 1'b1;
      n = 0;
      while (link.smmActiveAck !== 1'b1 && n < 40) begin
         @(posedge ref_clk);
         n++;
      end
      check(n < 40, 1);
      mgmtReq <= 1'b0;
   endtask : enter
   // Resume from the handler and wait, bounded, for the acknowledge to drop
   task automatic leave();
      int n;
      handlerDone <= 1'b1;
      @(posedge ref_clk);
      handlerDone <= 1'b0;
      n = 0;
      while (link.smmActiveAck !== 1'b0 && n < 20) begin
         @(posedge ref_clk);
         n++;
      end
      check(n < 20, 1);
      repeat (4) @(posedge ref_clk);
   endtask : leave
   // Pulse the NMI pin and report how many were serviced
   task automatic probeNmi(output int taken);
      int c;
      c = nmiCount;
      nmiPin <= 1'b1;
      @(posedge ref_clk);
      nmiPin <= 1'b0;
      repeat (5) @(posedge ref_clk);
      taken = nmiCount - c;
   endtask : probeNmi
   initial begin
      #200000;
      bad_count++;
      stop_test();
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      foreach (rows[i]) begin
         enter(rows[i].mode, rows[i].maskReq);
         repeat (6) @(posedge ref_clk);
         check(maskSeen, 0);
         check(link.maskIn, 0);
         check(mgmtPend, 0);
         probeNmi(got);
         check(got, 0);
         leave();
         check(link.maskIn, rows[i].maskReq);
         $display("case %0d done", i);
      end
      // Reset in mid-mode drops the mask, the request and the acknowledge
      enter(MODE_TIMED, 1'b1);
      rst <= 1'b1;
      repeat (10) @(posedge ref_clk);
      check({link.maskIn, link.smmRequest, link.smmActiveAck}, 0);
      rst <= 1'b0;
      $display("reset test done");
      // Interrupt flag plus a taken maskable interrupt reopens NMI
      enter(MODE_TIMED, 1'b0);
      ifFlag <= 1'b1;
      intrPin <= 1'b1;
      repeat (5) @(posedge ref_clk);
      intrPin <= 1'b0;
      ifFlag <= 1'b0;
      // Let the last taken pulse reach the counter before looking
      repeat (2) @(posedge ref_clk);
      check(intrCount > 0, 1);
      probeNmi(got);
      check(got, 1);
      leave();
      // A trap or fault exception reopens NMI as well
      enter(MODE_HOLD_REQ, 1'b1);
      // Exceptions only count once the save run is over and the handler runs
      repeat (4) @(posedge ref_clk);
      exceptEvt <= 1'b1;
      @(posedge ref_clk);
      exceptEvt <= 1'b0;
      probeNmi(got);
      check(got, 1);
      leave();
      $display("nmi reopen tests done");
      stop_test();
   end
endmodule : tb_smm_entry_addr_mask_gate
